// >>> design/urmd_regs.sv
// How it works
// - divisor bit clear: address 0 is receive/transmit
// - divisor bit set, no key: divisor bytes
// - zero divisor: revision and identity codes read
// - fraction at 2 needs divisor, no key, enhanced
// - divisor clear: address 1 is interrupt enable
// - address 2 reads status, writes fifo control
// - fifo control fields: enable, resets, wake, triggers
// - address 3 always holds line control
// - address 4 holds modem control fields
// - address 5 reads line status
// - address 5 write, no key: setup register
// - address 6 reads modem status
// - address 6 write, enhanced: special function
// - address 7, feature select: mode select, level
// - address 7 otherwise: scratch or pin level byte
// - key bank: level/trigger, feature, enhanced function
// - key bank page 0: flow characters
// - key bank page 1: pin control registers
// - enhanced bits in standard registers need enable
`timescale 1ns/1ps
`default_nettype none

module urmd_regs
    import urmd_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = 8'h01, // arbitrary value
    parameter logic [7:0] IDENTITY_CODE = 8'h5A  // arbitrary value
)(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [2:0]  addr_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic [7:0]  isr_i,
    input  wire logic [7:0]  lsr_i,
    input  wire logic [7:0]  msr_i,
    input  wire logic [7:0]  rx_level_i,
    input  wire logic [7:0]  tx_level_i,
    input  wire logic [15:0] pin_level_i,
    output logic             rx_pop_o,
    output logic             tx_push_o,
    output logic      [7:0]  tx_data_o,
    output logic             isr_rd_o,
    output logic             lsr_rd_o,
    output logic             msr_rd_o,
    output logic             rx_fifo_rst_o,
    output logic             tx_fifo_rst_o,
    output logic             fifo_trigger_level_wr_o,
    output logic      [7:0]  fifo_trigger_level_level_o,
    output logic      [15:0] divisor_o,
    output logic      [7:0]  divisor_frac_o,
    output logic      [7:0]  int_enable_o,
    output logic      [7:0]  fifo_ctrl_o,
    output logic      [7:0]  line_ctrl_o,
    output logic      [7:0]  modem_ctrl_o,
    output logic      [7:0]  setup_hyst_o,
    output logic      [7:0]  special_func_o,
    output logic      [7:0]  mode_select_o,
    output logic      [7:0]  feature_ctrl_o,
    output logic      [7:0]  enh_func_o,
    output logic      [7:0]  flow_on_first_o,
    output logic      [7:0]  flow_on_second_o,
    output logic      [7:0]  flow_off_first_o,
    output logic      [7:0]  flow_off_second_o,
    output logic      [7:0]  pin_int_en_o,
    output logic      [7:0]  pin_tristate_o,
    output logic      [7:0]  pin_polarity_o,
    output logic      [7:0]  pin_select_o,
    output logic      [15:0] pin_level_o
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0]  rdata;
        logic [7:0]  tx_data;
        logic        rx_pop;
        logic        tx_push;
        logic        isr_rd;
        logic        lsr_rd;
        logic        msr_rd;
        logic        rx_rst;
        logic        tx_rst;
        logic        fifo_trigger_level_wr;
        logic [7:0]  fifo_trigger_level;
        logic [7:0]  dll;
        logic [7:0]  divisor_high;
        logic [7:0]  divisor_fraction;
        logic [7:0]  interrupt_enable_reg;
        logic [7:0]  fifo_control_reg;
        logic [7:0]  line_control_reg;
        logic [7:0]  modem_control_reg;
        logic [7:0]  shr;
        logic [7:0]  special_function_reg;
        logic [7:0]  scratch_reg;
        logic [7:0]  enhanced_mode_select;
        logic [7:0]  feature_control_reg;
        logic [7:0]  enhanced_function_reg;
        logic [7:0]  xon1;
        logic [7:0]  xon2;
        logic [7:0]  xoff1;
        logic [7:0]  xoff2;
        logic [7:0]  gint;
        logic [7:0]  g3t;
        logic [7:0]  ginv;
        logic [7:0]  gsel;
        logic [15:0] gout;
    } urmd_state_t;

    urmd_state_t s_q;
    urmd_state_t s_d;

    // enhanced-only bits read and act as zero while enhanced enable is off
    function automatic logic [7:0] urmd_gate(input logic [7:0] val,
                                             input logic [7:0] std_mask,
                                             input logic       enh);
        urmd_gate = enh ? val : (val & std_mask);
    endfunction : urmd_gate

    // ****************************************
    // bank decode
    // ****************************************
    logic key_w;
    logic div_w;
    logic enh_w;
    logic page_w;
    logic div_zero_w;
    logic [7:0] fc_w;
    logic [7:0] pin_rd_w;

    // the whole line control byte, not just the divisor bit, picks the bank
    assign key_w      = (s_q.line_control_reg == LCR_KEY);
    assign div_w      = s_q.line_control_reg[LCR_DIV_BIT] && !key_w;
    assign enh_w      = s_q.enhanced_function_reg[EFR_ENH_BIT];
    assign page_w     = s_q.special_function_reg[SFR_PAGE_BIT];
    assign div_zero_w = (s_q.dll == DIV_ZERO) && (s_q.divisor_high == DIV_ZERO);
    assign fc_w       = s_q.feature_control_reg[FEATURE_CONTROL_REG_DIR_BIT] ? tx_level_i : rx_level_i;
    assign pin_rd_w   = s_q.special_function_reg[SFR_BANK_BIT] ? pin_level_i[15:8] : pin_level_i[7:0];

    // ****************************************
    // next state
    // ****************************************
    // one process serves reads and writes; a read loads rdata for the next cycle
    always_comb
    begin
        s_d         = s_q;
        s_d.rx_pop  = 1'b0;
        s_d.tx_push = 1'b0;
        s_d.isr_rd  = 1'b0;
        s_d.lsr_rd  = 1'b0;
        s_d.msr_rd  = 1'b0;
        s_d.rx_rst  = 1'b0;
        s_d.tx_rst  = 1'b0;
        s_d.fifo_trigger_level_wr = 1'b0;
        if (rd_i)
        begin
            unique case (addr_i)
                ADR_HOLD:
                begin
                    if (key_w)
                        s_d.rdata = fc_w;
                    else if (div_w)
                        s_d.rdata = div_zero_w ? REVISION_CODE : s_q.dll;
                    else
                    begin
                        s_d.rdata  = rx_data_i;
                        s_d.rx_pop = 1'b1;
                    end
                end
                ADR_IER:
                begin
                    if (key_w)
                        s_d.rdata = s_q.feature_control_reg;
                    else if (div_w)
                        s_d.rdata = div_zero_w ? IDENTITY_CODE : s_q.divisor_high;
                    else
                        s_d.rdata = urmd_gate(s_q.interrupt_enable_reg, IER_STD_MASK, enh_w);
                end
                ADR_ISR:
                begin
                    if (key_w)
                        s_d.rdata = s_q.enhanced_function_reg;
                    else if (div_w && enh_w)
                        s_d.rdata = s_q.divisor_fraction;
                    else
                    begin
                        s_d.rdata  = isr_i;
                        s_d.isr_rd = 1'b1;
                    end
                end
                ADR_LCR:
                    s_d.rdata = s_q.line_control_reg;
                ADR_MCR:
                begin
                    if (key_w)
                        s_d.rdata = page_w ? s_q.gint : s_q.xon1;
                    else
                        s_d.rdata = urmd_gate(s_q.modem_control_reg, MCR_STD_MASK, enh_w);
                end
                ADR_LSR:
                begin
                    if (key_w)
                        s_d.rdata = page_w ? s_q.g3t : s_q.xon2;
                    else
                    begin
                        s_d.rdata  = lsr_i;
                        s_d.lsr_rd = 1'b1;
                    end
                end
                ADR_MSR:
                begin
                    if (key_w)
                        s_d.rdata = page_w ? s_q.ginv : s_q.xoff1;
                    else
                    begin
                        s_d.rdata  = msr_i;
                        s_d.msr_rd = 1'b1;
                    end
                end
                ADR_SPR:
                begin
                    if (key_w)
                        s_d.rdata = page_w ? s_q.gsel : s_q.xoff2;
                    else if (s_q.feature_control_reg[FEATURE_CONTROL_REG_SEL_BIT])
                        s_d.rdata = fc_w;
                    else
                        s_d.rdata = page_w ? pin_rd_w : s_q.scratch_reg;
                end
            endcase
        end
        // a write in the same cycle as a read is honoured too; the host should not do both
        if (wr_i)
        begin
            unique case (addr_i)
                ADR_HOLD:
                begin
                    if (key_w)
                    begin
                        s_d.fifo_trigger_level    = wdata_i;
                        s_d.fifo_trigger_level_wr = 1'b1;
                    end
                    else if (div_w)
                        s_d.dll = wdata_i;
                    else
                    begin
                        s_d.tx_data = wdata_i;
                        s_d.tx_push = 1'b1;
                        s_d.special_function_reg[SFR_TX9_BIT] = 1'b0; // nine-bit flag covers one byte only
                    end
                end
                ADR_IER:
                begin
                    if (key_w)
                        s_d.feature_control_reg = wdata_i;
                    else if (div_w)
                        s_d.divisor_high = wdata_i;
                    else
                        s_d.interrupt_enable_reg = urmd_gate(wdata_i, IER_STD_MASK, enh_w);
                end
                ADR_ISR:
                begin
                    if (key_w)
                        s_d.enhanced_function_reg = wdata_i;
                    else if (div_w && enh_w)
                        s_d.divisor_fraction = wdata_i;
                    else
                    begin
                        // fifo resets are pulses; the other fields are held
                        s_d.fifo_control_reg    = urmd_gate(wdata_i, FCR_STD_MASK, enh_w)
                                     & FCR_KEEP_MASK;
                        s_d.rx_rst = wdata_i[FCR_RXRST_BIT];
                        s_d.tx_rst = wdata_i[FCR_TXRST_BIT];
                    end
                end
                ADR_LCR:
                    s_d.line_control_reg = wdata_i;
                ADR_MCR:
                begin
                    if (key_w && page_w)
                        s_d.gint = wdata_i;
                    else if (key_w)
                        s_d.xon1 = wdata_i;
                    else
                        s_d.modem_control_reg = urmd_gate(wdata_i, MCR_STD_MASK, enh_w);
                end
                ADR_LSR:
                begin
                    if (key_w && page_w)
                        s_d.g3t = wdata_i;
                    else if (key_w)
                        s_d.xon2 = wdata_i;
                    else
                        s_d.shr = wdata_i;
                end
                ADR_MSR:
                begin
                    if (key_w && page_w)
                        s_d.ginv = wdata_i;
                    else if (key_w)
                        s_d.xoff1 = wdata_i;
                    else if (enh_w)
                        s_d.special_function_reg = wdata_i;
                end
                ADR_SPR:
                begin
                    if (key_w && page_w)
                        s_d.gsel = wdata_i;
                    else if (key_w)
                        s_d.xoff2 = wdata_i;
                    else if (s_q.feature_control_reg[FEATURE_CONTROL_REG_SEL_BIT])
                        s_d.enhanced_mode_select = wdata_i;
                    else if (page_w && s_q.special_function_reg[SFR_BANK_BIT])
                        s_d.gout[15:8] = wdata_i;
                    else if (page_w)
                        s_d.gout[7:0] = wdata_i;
                    else
                        s_d.scratch_reg = wdata_i;
                end
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // synchronous reset; every register and pulse starts at zero
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            s_q      <= '0;
            s_q.line_control_reg  <= REG_RST;
            s_q.gout <= PIN_RST;
        end
        else
            s_q <= s_d;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign rdata_o           = s_q.rdata;
    assign rx_pop_o          = s_q.rx_pop;
    assign tx_push_o         = s_q.tx_push;
    assign tx_data_o         = s_q.tx_data;
    assign isr_rd_o          = s_q.isr_rd;
    assign lsr_rd_o          = s_q.lsr_rd;
    assign msr_rd_o          = s_q.msr_rd;
    assign rx_fifo_rst_o     = s_q.rx_rst;
    assign tx_fifo_rst_o     = s_q.tx_rst;
    assign fifo_trigger_level_wr_o         = s_q.fifo_trigger_level_wr;
    assign fifo_trigger_level_level_o      = s_q.fifo_trigger_level;
    assign divisor_o         = {s_q.divisor_high, s_q.dll};
    assign divisor_frac_o    = s_q.divisor_fraction;
    assign int_enable_o      = urmd_gate(s_q.interrupt_enable_reg, IER_STD_MASK, enh_w);
    assign fifo_ctrl_o       = urmd_gate(s_q.fifo_control_reg, FCR_STD_MASK, enh_w);
    assign line_ctrl_o       = s_q.line_control_reg;
    assign modem_ctrl_o      = urmd_gate(s_q.modem_control_reg, MCR_STD_MASK, enh_w);
    assign setup_hyst_o      = s_q.shr;
    assign special_func_o    = s_q.special_function_reg;
    assign mode_select_o     = s_q.enhanced_mode_select;
    assign feature_ctrl_o    = s_q.feature_control_reg;
    assign enh_func_o        = s_q.enhanced_function_reg;
    assign flow_on_first_o   = s_q.xon1;
    assign flow_on_second_o  = s_q.xon2;
    assign flow_off_first_o  = s_q.xoff1;
    assign flow_off_second_o = s_q.xoff2;
    assign pin_int_en_o      = s_q.gint;
    assign pin_tristate_o    = s_q.g3t;
    assign pin_polarity_o    = s_q.ginv;
    assign pin_select_o      = s_q.gsel;
    assign pin_level_o       = s_q.gout;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    thr_push_a: assert property (wr_i && addr_i == ADR_HOLD && !line_ctrl_o[LCR_DIV_BIT]
        |=> tx_push_o && tx_data_o == $past(wdata_i))
        else $error("transmit write not pushed");
    rhr_pop_a: assert property (rd_i && addr_i == ADR_HOLD && !line_ctrl_o[LCR_DIV_BIT]
        |=> rx_pop_o && rdata_o == $past(rx_data_i) ##1 (!rx_pop_o || $past(rd_i)))
        else $error("receive read wrong");
    div_write_a: assert property (wr_i && addr_i == ADR_IER && div_w
        |=> divisor_o[15:8] == $past(wdata_i))
        else $error("divisor high not written");
    rev_read_a: assert property (rd_i && addr_i == ADR_HOLD && div_w && div_zero_w
        |=> rdata_o == REVISION_CODE)
        else $error("revision code not returned");
    frac_gate_a: assert property (wr_i && addr_i == ADR_ISR && div_w && !enh_w
        |=> $stable(divisor_frac_o))
        else $error("fraction written without enable");
    // the stored byte, not the gated output, so a later enable cannot revive old bits
    ier_gate_a: assert property (wr_i && addr_i == ADR_IER && !enh_w
        && !key_w && !div_w |=> s_q.interrupt_enable_reg[7:4] == 4'h0)
        else $error("enhanced enable bits stored");
    fifo_reset_a: assert property (wr_i && addr_i == ADR_ISR && !key_w && !div_w
        && wdata_i[FCR_RXRST_BIT] && !(wr_i && rd_i) |=> rx_fifo_rst_o)
        else $error("receive fifo reset pulse missing");
    lcr_write_a: assert property (wr_i && addr_i == ADR_LCR
        |=> line_ctrl_o == $past(wdata_i))
        else $error("line control not written");
    lsr_read_a: assert property (rd_i && addr_i == ADR_LSR && !key_w
        |=> rdata_o == $past(lsr_i) && lsr_rd_o)
        else $error("line status read wrong");
    flow_char_a: assert property (wr_i && addr_i == ADR_MSR && key_w && !page_w
        |=> flow_off_first_o == $past(wdata_i))
        else $error("first off character not written");

endmodule : urmd_regs

`default_nettype wire

// >>> design/urmd_pkg.sv
package urmd_pkg;
    // ****************************************
    // register offsets on the three-bit address
    // ****************************************
    localparam logic [2:0] ADR_HOLD   = 3'h0; // holding, divisor low, revision, level count
    localparam logic [2:0] ADR_IER    = 3'h1; // interrupt enable, divisor high, identity, feature
    localparam logic [2:0] ADR_ISR    = 3'h2; // status / fifo control, fraction, enhanced func
    localparam logic [2:0] ADR_LCR    = 3'h3;
    localparam logic [2:0] ADR_MCR    = 3'h4; // modem control / first on-char / pin int enable
    localparam logic [2:0] ADR_LSR    = 3'h5; // line status, setup / second on-char / tristate
    localparam logic [2:0] ADR_MSR    = 3'h6; // modem status, special / first off-char / polarity
    localparam logic [2:0] ADR_SPR    = 3'h7; // scratch, level, mode select / second off-char

    // ****************************************
    // bank select values and bit positions
    // ****************************************
    localparam logic [7:0] LCR_KEY      = 8'hBF; // opens the enhanced bank
    localparam int         LCR_DIV_BIT  = 7;
    localparam int         EFR_ENH_BIT  = 4;
    localparam int         FEATURE_CONTROL_REG_SEL_BIT = 6;     // level count / mode select vs scratch
    localparam int         FEATURE_CONTROL_REG_DIR_BIT = 7;     // level count direction, 0 receive 1 transmit
    localparam int         SFR_PAGE_BIT = 0;     // pin register page
    localparam int         SFR_BANK_BIT = 1;     // pin level bits 15:8 when set
    localparam int         SFR_TX9_BIT  = 7;     // self-clearing after a transmit write
    localparam int         FCR_RXRST_BIT = 1;
    localparam int         FCR_TXRST_BIT = 2;

    // ****************************************
    // masks of standard bits usable without enhanced enable, and of stored fifo control bits
    // ****************************************
    localparam logic [7:0] IER_STD_MASK = 8'h0F;
    localparam logic [7:0] MCR_STD_MASK = 8'h1F;
    localparam logic [7:0] FCR_STD_MASK = 8'hC7;
    localparam logic [7:0] FCR_KEEP_MASK = 8'hF9; // reset bits are pulses, not stored

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0]  REG_RST  = 8'h00;
    localparam logic [15:0] PIN_RST  = 16'h0000;
    localparam logic [7:0]  DIV_ZERO = 8'h00;
endpackage : urmd_pkg

// >>> test/urmd_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// engine stand-in behind the register bank
// ****************************************
module urmd_engine_model #(
    parameter logic [7:0]  ISR_V = 8'hC1,
    parameter logic [7:0]  LSR_V = 8'h60,
    parameter logic [7:0]  MSR_V = 8'hB0,
    parameter logic [7:0]  RXL_V = 8'h11,
    parameter logic [7:0]  TXL_V = 8'h22,
    parameter logic [15:0] PIN_V = 16'h9C3D
)(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        rx_pop_i,
    input  wire logic        tx_push_i,
    input  wire logic [7:0]  tx_data_i,
    output logic      [7:0]  rx_data_o,
    output logic      [7:0]  last_tx_o,
    output logic      [7:0]  isr_o,
    output logic      [7:0]  lsr_o,
    output logic      [7:0]  msr_o,
    output logic      [7:0]  rx_level_o,
    output logic      [7:0]  tx_level_o,
    output logic      [15:0] pin_level_o
);
    // fixed status, distinct per register so a wrong decode shows
    assign isr_o       = ISR_V;
    assign lsr_o       = LSR_V;
    assign msr_o       = MSR_V;
    assign rx_level_o  = RXL_V;
    assign tx_level_o  = TXL_V;
    assign pin_level_o = PIN_V;
    // receive byte advances per pop, transmit byte captured per push
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            rx_data_o <= 8'hA0;
            last_tx_o <= 8'h00;
        end
        else
        begin
            if (rx_pop_i) rx_data_o <= rx_data_o + 8'h01;
            if (tx_push_i) last_tx_o <= tx_data_i;
        end
    end
endmodule : urmd_engine_model
`default_nettype wire

// >>> test/urmd_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module urmd_regs_bench;
    import urmd_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wd = 8'h00, rdata, rxd, ltx, interrupt_status_reg, line_status_reg, modem_status_reg, rxl, txl;
    logic [7:0] tdat, trl, ie, fc, lc, mc, sh, sf, ms, fct, ef, n1, n2, f1, f2, pie, pt, pp, ps;
    logic [15:0] pin, pin_o, dv;
    logic [7:0] dfr;
    logic pop, push, rxr, txr, trw, ird, lrd, mrd;
    int num_errors = 0, compares = 0, cycles = 0;
    // ****************************************
    // clock, engine model, design
    // ****************************************
    initial forever #10 clk = ~clk;
    urmd_engine_model urmd_engine_model_i (.core_clk_i(clk), .rst_b_i(rst_b), .rx_pop_i(pop),
        .tx_push_i(push), .tx_data_i(tdat), .rx_data_o(rxd), .last_tx_o(ltx), .isr_o(interrupt_status_reg),
        .lsr_o(line_status_reg), .msr_o(modem_status_reg), .rx_level_o(rxl), .tx_level_o(txl), .pin_level_o(pin));
    urmd_regs urmd_regs_i (.core_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .rd_i(rd),
        .wr_i(wr), .wdata_i(wd), .rdata_o(rdata), .rx_data_i(rxd), .isr_i(interrupt_status_reg), .lsr_i(line_status_reg),
        .msr_i(modem_status_reg), .rx_level_i(rxl), .tx_level_i(txl), .pin_level_i(pin), .rx_pop_o(pop),
        .tx_push_o(push), .tx_data_o(tdat), .isr_rd_o(ird), .lsr_rd_o(lrd), .msr_rd_o(mrd),
        .rx_fifo_rst_o(rxr), .tx_fifo_rst_o(txr), .fifo_trigger_level_wr_o(trw), .fifo_trigger_level_level_o(trl),
        .divisor_o(dv), .divisor_frac_o(dfr), .int_enable_o(ie), .fifo_ctrl_o(fc),
        .line_ctrl_o(lc), .modem_ctrl_o(mc), .setup_hyst_o(sh), .special_func_o(sf),
        .mode_select_o(ms), .feature_ctrl_o(fct), .enh_func_o(ef), .flow_on_first_o(n1),
        .flow_on_second_o(n2), .flow_off_first_o(f1), .flow_off_second_o(f2),
        .pin_int_en_o(pie), .pin_tristate_o(pt), .pin_polarity_o(pp), .pin_select_o(ps),
        .pin_level_o(pin_o));
    // ****************************************
    // one-cycle strobes; result sampled 1 ns after the taking edge
    // ****************************************
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wreg
    task automatic rreg(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask : rreg
    task automatic tally_and_finish;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    // hang guard, the sequence needs well under 400 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end
    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        `CHK(dv, 16'h0000)
        rreg(ADR_LCR, 8'h00);
        $display("reset test done");
        wreg(ADR_HOLD, 8'h41); `CHK(push, 1'b1)
        `CHK(tdat, 8'h41)
        rreg(ADR_HOLD, 8'hA0); `CHK(pop, 1'b1)
        wreg(ADR_IER, 8'hFF); rreg(ADR_IER, IER_STD_MASK);
        wreg(ADR_MCR, 8'hFF); `CHK(mc, MCR_STD_MASK)
        rreg(ADR_ISR, 8'hC1); `CHK(ird, 1'b1)
        rreg(ADR_LSR, 8'h60); `CHK(lrd, 1'b1)
        rreg(ADR_MSR, 8'hB0); `CHK(mrd, 1'b1)
        wreg(ADR_ISR, 8'h3F); `CHK(rxr & txr, 1'b1)
        `CHK(fc, 8'h3F & FCR_KEEP_MASK & FCR_STD_MASK)
        wreg(ADR_LSR, 8'hA5); `CHK(sh, 8'hA5)
        wreg(ADR_MSR, 8'h55); `CHK(sf, 8'h00)
        wreg(ADR_SPR, 8'h3C); rreg(ADR_SPR, 8'h3C);
        $display("standard bank test done");
        wreg(ADR_LCR, 8'h80); rreg(ADR_HOLD, 8'h01); rreg(ADR_IER, 8'h5A);
        wreg(ADR_HOLD, 8'h12); wreg(ADR_IER, 8'h34); `CHK(dv, 16'h3412)
        rreg(ADR_HOLD, 8'h12); rreg(ADR_IER, 8'h34);
        wreg(ADR_ISR, 8'h09); `CHK(dfr, 8'h00)
        $display("divisor test done");
        wreg(ADR_LCR, LCR_KEY); wreg(ADR_ISR, 8'h10); wreg(ADR_IER, 8'h00);
        rreg(ADR_ISR, 8'h10); rreg(ADR_HOLD, 8'h11);
        `CHK({ef, fct}, 16'h1000)
        wreg(ADR_HOLD, 8'h20); `CHK({trw, trl}, 9'h120)
        for (int i = 4; i < 8; i++) wreg(3'(i), 8'h60 + 8'(i));
        `CHK({n1, n2, f1, f2}, 32'h64656667)
        for (int i = 4; i < 8; i++) rreg(3'(i), 8'h60 + 8'(i));
        $display("flow character test done");
        wreg(ADR_LCR, 8'h80); wreg(ADR_ISR, 8'h09); `CHK(dfr, 8'h09)
        wreg(ADR_LCR, 8'h00); rreg(ADR_IER, IER_STD_MASK);
        wreg(ADR_IER, 8'hFF); `CHK(ie, 8'hFF)
        wreg(ADR_MCR, 8'hFF); `CHK(mc, 8'hFF)
        wreg(ADR_MSR, 8'h83); `CHK(sf, 8'h83)
        wreg(ADR_HOLD, 8'h77); `CHK(sf, 8'h03)
        wreg(ADR_SPR, 8'h5A); `CHK(pin_o, 16'h5A00)
        `CHK(ltx, 8'h77)
        rreg(ADR_SPR, 8'h9C);
        $display("enhanced standard test done");
        wreg(ADR_LCR, LCR_KEY);
        for (int i = 4; i < 8; i++) wreg(3'(i), 8'h70 + 8'(i));
        `CHK({pie, pt, pp, ps}, 32'h74757677)
        for (int i = 4; i < 8; i++) rreg(3'(i), 8'h70 + 8'(i));
        wreg(ADR_IER, 8'h40); wreg(ADR_ISR, 8'h00); wreg(ADR_LCR, 8'h00);
        `CHK(ie, IER_STD_MASK)
        `CHK(mc, MCR_STD_MASK)
        rreg(ADR_SPR, 8'h11); wreg(ADR_SPR, 8'h0C); `CHK(ms, 8'h0C)
        $display("pin page and mode test done");
        tally_and_finish();
    end
endmodule : urmd_regs_bench
`default_nettype wire
